/* verilog/sst_transceiver.sv */
// synchronous serial transceiver: apb registers, clock generation, shifter and pin steering
//
// Overview of operation
// - lsb first over clock, input, output
// - eight bits shift without software help
// - three-bit counter, request after eighth bit
// - stop after byte, clear progress bit
// - clock counter reloads from reload register
// - drive on first edge, sample second
// - enable bit hands clock and output pins to function
// - progress bit shows transfer running
// - rate field picks master clock source
// - source bit chooses master or slave
// - edge bit picks rising or falling
// - direction bit: receive only or duplex
// - clock pin direction forced by source
// - output pin direction forced by duplex
// - disabled: pins follow port direction
// - both ends share edge, master clocks
// - output pin may be open drain
// - data buffer holds transmit, receive byte
`timescale 1ns/1ps
module sst_transceiver
  import sst_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RESET,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // serial clock pin
  input  wire logic               SCK_IN,
  output logic                    SCK_OUT,
  output logic                    SCK_OE,
  // serial input pin
  input  wire logic               SI_IN,
  output logic                    SI_OUT,
  output logic                    SI_OE,
  // serial output pin
  input  wire logic               SO_IN,
  output logic                    SO_OUT,
  output logic                    SO_OE,
  // end of transfer request
  output logic                    END_OF_TRANSFER
);

  if (PADDR_W < 10) begin : g_addr_width_check
    $error("PADDR_W must be at least 10 to reach the register indices");
  end

  sst_mode_s  mode;
  sst_port_s  port;
  logic [7:0] serial_clock_reload;
  logic [7:0] serial_data_buffer;
  logic [7:0] shifter;
  logic [2:0] bit_count;
  logic [7:0] shift_clock_counter;
  logic [4:0] prescale;
  logic       sck_level;
  logic       so_level;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sck_prev;
  logic       si_prev;
  logic       eot;

  logic       wr_en;
  logic       rd_setup;
  logic [7:0] idx;
  logic       mapped;
  logic       master;
  logic       busy;
  logic       tick;
  logic       expire;
  logic       sck_rise;
  logic       sck_fall;
  logic       lead;
  logic       trail;
  logic       last_bit;
  logic [7:0] next_shifter;

  // pin synchronisers: sync_b is the only reader of sync_a
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {SO_IN, SI_IN, SCK_IN};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sck_prev <= 1'b0;
      si_prev  <= 1'b0;
    end else begin
      sck_prev <= sync_b[0];
      si_prev  <= sync_b[1];
    end
  end

  // apb decode; printed offsets are indices, so the word address is paddr[9:2]
  assign idx      = PADDR[9:2];
  assign mapped   = (PADDR[PADDR_W-1:10] == '0) && (PADDR[1:0] == 2'h0) &&
                    (idx >= IDX_MODE_CONTROL) && (idx <= IDX_PIN_LEVEL);
  assign wr_en    = PSEL && PENABLE && PWRITE && mapped;
  assign rd_setup = PSEL && !PENABLE;
  assign PREADY   = 1'b1;

  assign master   = !mode.clock_source_select;
  // the end cycle already counts as idle, so no clock edge follows the last bit
  assign busy     = mode.serial_function_enable && mode.progress && !eot;

  // read data is captured in the setup phase so the access phase sees a flop
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (rd_setup) begin
      PSLVERR <= !mapped;
      PRDATA  <= 32'h0000_0000;
      if (mapped && !PWRITE) begin
        unique case (idx)
          IDX_MODE_CONTROL: PRDATA[7:0] <= {mode[7:4], 1'b0, mode[2:0]};
          IDX_DATA_BUFFER:  PRDATA[7:0] <= serial_data_buffer;
          IDX_PORT_CONTROL: PRDATA[7:0] <= {1'b0, port[6:0]};
          IDX_PIN_LEVEL:    PRDATA[2:0] <= sync_b;
          default:          PRDATA[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // mode register; a software write wins over the end-of-byte clear
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mode <= sst_mode_s'(RST_MODE_CONTROL);
    end else if (wr_en && idx == IDX_MODE_CONTROL) begin
      mode          <= sst_mode_s'(PWDATA[7:0]);
      mode.reserved <= 1'b0;
    end else if (eot || !mode.serial_function_enable) begin
      mode.progress <= 1'b0;
    end
  end

  // write-only reload value
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      serial_clock_reload <= RST_CLOCK_RELOAD;
    end else if (wr_en && idx == IDX_CLOCK_RELOAD) begin
      serial_clock_reload <= PWDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      port <= sst_port_s'(RST_PORT_CONTROL);
    end else if (wr_en && idx == IDX_PORT_CONTROL) begin
      port <= sst_port_s'({1'b0, PWDATA[6:0]});
    end
  end

  // the buffer is single: a write during a byte is overwritten by the received byte when the byte ends
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      serial_data_buffer <= RST_DATA_BUFFER;
    end else if (eot) begin
      serial_data_buffer <= shifter;
    end else if (wr_en && idx == IDX_DATA_BUFFER) begin
      serial_data_buffer <= PWDATA[7:0];
    end
  end

  // core clock prescaler for the master rate
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      prescale <= 5'h00;
    end else if (!busy || tick) begin
      prescale <= 5'h00;
    end else begin
      prescale <= prescale + 5'h01;
    end
  end

  always_comb begin
    unique case (mode.shift_rate_select)
      RATE_CORE:  tick = busy;
      RATE_DIV32: tick = busy && (prescale == DIV_BY_32);
      RATE_DIV16: tick = busy && (prescale == DIV_BY_16);
      RATE_DIV8:  tick = busy && (prescale == DIV_BY_8);
    endcase
  end

  // post-scaler: counts down from the reload value, one half period per expiry
  assign expire = tick && master && (shift_clock_counter == 8'h00);

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      shift_clock_counter <= 8'h00;
    end else if (!busy || expire) begin
      shift_clock_counter <= serial_clock_reload;
    end else if (tick) begin
      shift_clock_counter <= shift_clock_counter - 8'h01;
    end
  end

  // master clock idles at the level opposite to the first edge of a bit
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sck_level <= 1'b1;
    end else if (!busy || !master) begin
      sck_level <= !mode.shift_edge_select;
    end else if (expire) begin
      sck_level <= !sck_level;
    end
  end

  // slave edges come from the synchronised pin, two to three core cycles late
  assign sck_rise = sync_b[0] && !sck_prev;
  assign sck_fall = !sync_b[0] && sck_prev;

  always_comb begin
    if (master) begin
      lead  = expire && (sck_level != mode.shift_edge_select);
      trail = expire && (sck_level == mode.shift_edge_select);
    end else begin
      lead  = busy && (mode.shift_edge_select ? sck_rise : sck_fall);
      trail = busy && (mode.shift_edge_select ? sck_fall : sck_rise);
    end
  end

  assign last_bit     = trail && (bit_count == LAST_BIT);
  // a slave sees the clock edge in the same snapshot as a data change at that edge,
  // so it takes the input bit from the snapshot just before the edge
  assign next_shifter = {master ? sync_b[1] : si_prev, shifter[7:1]};

  // shifter: loaded when progress rises, fills lsb first from the top
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      shifter <= 8'h00;
    end else if (!busy) begin
      shifter <= serial_data_buffer;
    end else if (trail) begin
      shifter <= next_shifter;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      bit_count <= 3'h0;
    end else if (!busy) begin
      bit_count <= 3'h0;
    end else if (trail) begin
      bit_count <= bit_count + 3'h1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      so_level <= 1'b1;
    end else if (lead) begin
      so_level <= shifter[0];
    end
  end

  // one-cycle request; the mode and buffer updates follow it one cycle later, at the edge that ends it
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      eot <= 1'b0;
    end else begin
      eot <= last_bit;
    end
  end

  assign END_OF_TRANSFER = eot;

  // pin steering; the input pin is never forced, software keeps it an input
  always_comb begin
    if (mode.serial_function_enable) begin
      SCK_OE  = master;
      SCK_OUT = sck_level;
      SO_OE   = mode.duplex_direction_select && !(port.so_open_drain && so_level);
      SO_OUT  = so_level && !port.so_open_drain;
    end else begin
      SCK_OE  = port.port_direction_register[0];
      SCK_OUT = port.port_data[0];
      SO_OE   = port.port_direction_register[2];
      SO_OUT  = port.port_data[2];
    end
    SI_OE  = port.port_direction_register[1];
    SI_OUT = port.port_data[1];
  end

  // checks
  eot_stops_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    last_bit && !(wr_en && idx == IDX_MODE_CONTROL) |=> eot ##1 !mode.progress)
    else $error("progress not cleared after the last bit");

  eight_bits_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    trail && bit_count != LAST_BIT |=> !eot && bit_count == $past(bit_count) + 3'h1)
    else $error("bit counter did not advance on a sample edge");

  rx_store_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    last_bit |=> END_OF_TRANSFER ##1 serial_data_buffer == $past(next_shifter, 2))
    else $error("received byte not stored at end of byte");

  start_load_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !busy ##1 busy |-> shifter == $past(serial_data_buffer) && bit_count == 3'h0)
    else $error("shifter not loaded from the buffer at start");

  lead_drive_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    lead |=> so_level == $past(shifter[0]) ##1 $stable(so_level) || lead)
    else $error("output bit not driven on the first edge");

  reload_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    expire && busy |=> shift_clock_counter == $past(serial_clock_reload))
    else $error("clock counter did not reload on expiry");

  rate_core_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    busy && mode.shift_rate_select == RATE_CORE |-> tick)
    else $error("core rate does not tick every cycle");

  sck_idle_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    mode.serial_function_enable && master && !busy ##1
      mode.serial_function_enable && master && !busy && $stable(mode) |->
      SCK_OUT == !mode.shift_edge_select && SCK_OE)
    else $error("master clock not idle between transfers");

  so_dir_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    mode.serial_function_enable && !mode.duplex_direction_select |-> !SO_OE)
    else $error("output pin driven in receive only mode");

  open_drain_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    mode.serial_function_enable && port.so_open_drain && SO_OE |-> !SO_OUT)
    else $error("open drain output drove a high level");

  sck_dir_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    mode.serial_function_enable |-> SCK_OE == !mode.clock_source_select)
    else $error("clock pin direction not forced by source");

endmodule : sst_transceiver

/* verilog/sst_pkg.sv */
// constants, register map and carrier types of the synchronous serial transceiver
package sst_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_MODE_CONTROL  = 8'hb4;
  localparam logic [7:0] IDX_CLOCK_RELOAD  = 8'hb5;
  localparam logic [7:0] IDX_DATA_BUFFER   = 8'hb6;
  localparam logic [7:0] IDX_PORT_CONTROL  = 8'hb7;
  localparam logic [7:0] IDX_PIN_LEVEL     = 8'hb8;

  // values after reset
  localparam logic [7:0] RST_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_CLOCK_RELOAD  = 8'h00;
  localparam logic [7:0] RST_DATA_BUFFER   = 8'h00;
  localparam logic [7:0] RST_PORT_CONTROL  = 8'h00;

  // field positions of the mode register
  localparam int POS_ENABLE   = 7;
  localparam int POS_PROGRESS = 6;
  localparam int POS_RATE     = 4;
  localparam int POS_SOURCE   = 2;
  localparam int POS_EDGE     = 1;
  localparam int POS_DUPLEX   = 0;

  // shift rate divisors of the core clock
  localparam logic [4:0] DIV_BY_32 = 5'h1f;
  localparam logic [4:0] DIV_BY_16 = 5'h0f;
  localparam logic [4:0] DIV_BY_8  = 5'h07;

  // bits per byte and the last bit index
  localparam int          BYTE_BITS = 8;
  localparam logic [2:0]  LAST_BIT  = 3'h7;

  typedef enum logic [1:0] {
    RATE_CORE,
    RATE_DIV32,
    RATE_DIV16,
    RATE_DIV8
  } sst_rate_e;

  // mode register image, bit 3 reserved
  typedef struct packed {
    logic      serial_function_enable;
    logic      progress;
    sst_rate_e shift_rate_select;
    logic      reserved;
    logic      clock_source_select;
    logic      shift_edge_select;
    logic      duplex_direction_select;
  } sst_mode_s;

  // port control: output levels, open-drain select, direction (1 = output)
  typedef struct packed {
    logic       reserved;
    logic [2:0] port_data;
    logic       so_open_drain;
    logic [2:0] port_direction_register;
  } sst_port_s;

endpackage : sst_pkg

/* verif/sst_link_peer.sv */
// behavioural far-end peer of the serial link: swaps one byte and can supply the clock
`timescale 1ns/1ps
module sst_link_peer (
  // link pins
  input  wire logic       sck,
  input  wire logic       so,
  output logic            si,
  output logic            sck_drv,
  output logic            sck_oe,
  // settings and result
  input  wire logic       edge_sel,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  int lead_cnt = 8;
  int samp_cnt = 8;
  initial begin
    si = 1'b0;
    sck_drv = 1'b1;
    sck_oe = 1'b0;
    rx_byte = 8'h00;
  end
  // lead edge drives the next bit, the opposite edge samples
  always @(sck) begin
    if (sck === edge_sel && lead_cnt < 8) begin
      si <= tx_byte[lead_cnt];
      lead_cnt <= lead_cnt + 1;
    end else if (sck === ~edge_sel && samp_cnt < lead_cnt) begin
      rx_byte <= {so, rx_byte[7:1]};
      samp_cnt <= samp_cnt + 1;
      // hold time over after the last bit: show a changed level, not the old one
      if (samp_cnt == 7) si <= ~si;
    end
  end
  task automatic arm(input logic drive_clock);
    lead_cnt = 0;
    samp_cnt = 0;
    sck_drv <= ~edge_sel;
    sck_oe <= drive_clock;
  endtask : arm
  task automatic clock_byte;
    // offset puts the link clock edges 12 ns after core clock rising edges, in a fixed phase to them
    #37;
    repeat (16) begin
      sck_drv = ~sck_drv;
      #100;
    end
    sck_oe = 1'b0;
  endtask : clock_byte
endmodule : sst_link_peer

/* verif/sst_transceiver_tb_top.sv */
// self-checking testbench of the synchronous serial transceiver
`timescale 1ns/1ps
module sst_transceiver_tb_top
  import sst_pkg::*;
;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sck_out, sck_oe, si_out, si_oe, so_out, so_oe, end_of_transfer;
  logic        p_si, p_sck, p_sck_oe, p_edge, sck_prev, od_on, od_bad;
  logic [7:0]  ptx, p_rx;
  int          miscompares, checks_done, cyc, toggles, t_first, t_last, eots;
  // pull-ups on the clock and output lines; open drain relies on them
  wire         sck_w = sck_oe ? sck_out : (p_sck_oe ? p_sck : 1'b1);
  wire         so_w = so_oe ? so_out : 1'b1;
  wire         si_w = si_oe ? si_out : p_si;

  sst_transceiver sst_transceiver_i (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCK_IN(sck_w), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SI_IN(si_w), .SI_OUT(si_out), .SI_OE(si_oe),
    .SO_IN(so_w), .SO_OUT(so_out), .SO_OE(so_oe), .END_OF_TRANSFER(end_of_transfer));
  sst_link_peer sst_link_peer_i (.sck(sck_w), .so(so_w), .si(p_si), .sck_drv(p_sck), .sck_oe(p_sck_oe),
    .edge_sel(p_edge), .tx_byte(ptx), .rx_byte(p_rx));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, v, d, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 8'h00, d, e);
    chk(what, exp, d);
  endtask : rd_chk

  task automatic xfer(input logic [7:0] mode, input logic [7:0] rel, input int div, input logic [7:0] pc,
                      input string name);
    logic [31:0] d;
    logic        e;
    logic        slave;
    logic [7:0]  dtx;
    slave = mode[POS_SOURCE];
    dtx = 8'ha5 ^ mode;
    ptx = 8'h3c ^ rel ^ mode;
    p_edge = mode[POS_EDGE];
    od_on = pc[3];
    wr(IDX_PORT_CONTROL, pc);
    wr(IDX_CLOCK_RELOAD, rel);
    wr(IDX_DATA_BUFFER, dtx);
    wr(IDX_MODE_CONTROL, mode);
    repeat (4) @(posedge sys_clk);
    sst_link_peer_i.arm(slave);
    toggles = 0;
    eots = 0;
    od_bad = 1'b0;
    wr(IDX_MODE_CONTROL, mode | 8'h40);
    rd_chk(IDX_MODE_CONTROL, mode | 8'h40, "progress set");
    if (slave) sst_link_peer_i.clock_byte();
    do apb(1'b0, IDX_MODE_CONTROL, 8'h00, d, e); while (d[POS_PROGRESS] !== 1'b0);
    rd_chk(IDX_DATA_BUFFER, ptx, "received byte");
    chk("end pulses", 1, eots);
    chk("clock pin enable", !slave, sck_oe);
    if (!pc[3]) chk("output pin enable", mode[POS_DUPLEX], so_oe);
    chk("open drain high", 0, od_bad);
    chk("sent byte", mode[POS_DUPLEX] ? dtx : 8'hff, p_rx);
    if (!slave) begin
      chk("clock toggles", 16, toggles);
      chk("frame span", 15 * (rel + 1) * div, t_last - t_first);
    end
    $display("test %s done", name);
  endtask : xfer

  // monitor of the link clock, end pulses and open-drain drive, plus hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (end_of_transfer === 1'b1) eots++;
    if (od_on && so_oe === 1'b1 && so_out === 1'b1) od_bad = 1'b1;
    if (sck_w !== sck_prev) begin
      if (toggles == 0) t_first = cyc;
      t_last = cyc;
      toggles++;
    end
    sck_prev = sck_w;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    logic [31:0] d;
    logic        e;
    reset = 1'b1;
    {psel, penable, pwrite, p_edge, od_on, od_bad, sck_prev} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ptx = 8'h00;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(IDX_MODE_CONTROL, RST_MODE_CONTROL, "mode after reset");
    rd_chk(IDX_DATA_BUFFER, RST_DATA_BUFFER, "buffer after reset");
    wr(IDX_CLOCK_RELOAD, 8'h5a);
    rd_chk(IDX_CLOCK_RELOAD, 32'h0000_0000, "reload write only");
    wr(IDX_MODE_CONTROL, 8'h0f);
    rd_chk(IDX_MODE_CONTROL, 32'h0000_0007, "reserved mode bit");
    apb(1'b0, 8'hc0, 8'h00, d, e);
    chk("unmapped error", 1, e);
    $display("test registers done");
    wr(IDX_PORT_CONTROL, 8'h75);
    @(posedge sys_clk);
    chk("port pins 101", 3'b101, {so_oe, si_oe, sck_oe});
    chk("port levels", 3'h7, {so_out, si_out, sck_out});
    rd_chk(IDX_PIN_LEVEL, 32'h0000_0005, "pin levels");
    wr(IDX_PORT_CONTROL, 8'h02);
    @(posedge sys_clk);
    chk("port pins 010", 3'b010, {so_oe, si_oe, sck_oe});
    $display("test disabled pins done");
    xfer(8'h83, 8'h02, 1, 8'h08, "master rising open drain");
    xfer(8'h91, 8'h01, 32, 8'h00, "master falling div32");
    xfer(8'ha3, 8'h01, 16, 8'h00, "master rising div16");
    xfer(8'hb1, 8'h01, 8, 8'h00, "master falling div8");
    xfer(8'h82, 8'h02, 1, 8'h04, "master receive only");
    xfer(8'hb7, 8'h00, 1, 8'h01, "slave rising duplex");
    results();
  end
endmodule : sst_transceiver_tb_top
